// *** rtl/trig_sync_pkg.sv ***
// Shared constants, types and helpers for the multi-board trigger synchroniser.
package trig_sync_pkg;

   // Clock timing: pclk runs at 20 MHz.
   localparam int CLK_PERIOD_NS = 50;
   localparam int US_NS = 1000;
   localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;

   // Fixed sync pulse of the forwarding master mode, a least time, rounded up.
   localparam int SYNC_PULSE_NS = 1000;
   localparam int SYNC_PULSE_CYCLES = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] SYNC_PULSE_LOAD = 6'(SYNC_PULSE_CYCLES);

   // Last value of the microsecond prescaler in the debouncer.
   localparam logic [4:0] PRESC_LAST = 5'(CYCLES_PER_US - 1);

   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_DEBOUNCE = 8'h04;
   localparam logic [7:0] OFS_CC1_WIDTH = 8'h08;
   localparam logic [7:0] OFS_COMMAND = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_ACCEPT_CNT = 8'h14;
   localparam logic [7:0] OFS_IGNORE_CNT = 8'h18;

   // Values after reset.
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] DEBOUNCE_RESET = 8'h01;
   localparam logic [15:0] CC1_WIDTH_RESET = 16'h0014;

   // Command register bit positions; each written one gives a single pulse.
   localparam int CMD_ARM_BIT = 0;
   localparam int CMD_DISARM_BIT = 1;
   localparam int CMD_SW_TRIG_BIT = 2;
   localparam int CMD_CLR_CNT_BIT = 3;

   // Values of trigger_source_select.
   typedef enum logic [2:0] {
      SRC_EXT = 3'h0,
      SRC_SW = 3'h1,
      SRC_MASTER_FWD = 3'h2,
      SRC_MASTER_CC1 = 3'h3,
      SRC_SLAVE = 3'h4
   } trig_src_t;

   // Configuration word: source in bits 2:0, then enable, level, detection, etc.
   typedef struct packed {
      logic cc1_low;
      logic use_sw;
      logic detect_trailing;
      logic level_low;
      logic trig_enable;
      trig_src_t src;
   } cfg_t;

   // Status word, bits 3:0.
   typedef struct packed {
      logic sync_level;
      logic sync_driving;
      logic pulse_busy;
      logic armed;
   } stat_t;

   // Acquisition control states, one-hot.
   typedef enum logic [2:0] {
      ACQ_IDLE = 3'b001,
      ACQ_ARMED = 3'b010,
      ACQ_PULSE = 3'b100
   } acq_state_t;

   // A programmed zero stands for the smallest legal value of one.
   function automatic logic [15:0] at_least_one(input logic [15:0] v);
      return (v == 16'h0000) ? 16'h0001 : v;
   endfunction

   // Merges the two low byte lanes of a write under their strobes.
   function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0] strb);
      logic [15:0] r;
      r = old_v;
      if (strb[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

endpackage

// *** rtl/trig_debounce.sv ***
// Glitch filter for the isolated external trigger level.
`timescale 1ns/100ps
module trig_debounce
   import trig_sync_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level_in,
   input wire logic [7:0] window_us,
   output logic level_out
);

   logic [4:0] presc_reg; // Cycles within the current microsecond.
   logic [7:0] us_cnt_reg; // Whole microseconds the input has differed.
   logic level_reg; // Filtered level.
   logic [15:0] window_full; // Window with zero mapped to one.
   logic [7:0] window_eff; // Effective window in microseconds.

   assign window_full = at_least_one({8'h00, window_us});
   assign window_eff = window_full[7:0];
   assign level_out = level_reg;

   // Time how long the input has differed from the filtered level; any return
   // to the old level restarts the count, so short pulses never pass.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_reg <= 5'h00;
         us_cnt_reg <= 8'h00;
      end else if (level_in == level_reg) begin
         presc_reg <= 5'h00;
         us_cnt_reg <= 8'h00;
      end else if (presc_reg == PRESC_LAST) begin
         presc_reg <= 5'h00;
         us_cnt_reg <= us_cnt_reg + 8'h01;
      end else begin
         presc_reg <= presc_reg + 5'h01;
      end
   end

   // Accept the new level once it has held for the whole window.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 1'b0;
      end else if (level_in != level_reg && presc_reg == PRESC_LAST &&
                   us_cnt_reg + 8'h01 >= window_eff) begin
         level_reg <= level_in;
      end
   end

endmodule

// *** rtl/board_trigger_sync.sv ***
// Multi-board trigger synchroniser with APB registers, CC1 pulse and sync line.
`timescale 1ns/100ps
// Contract
// - Triggered board masters the line; others slave.
// - Master trigger from external or software.
// - Forwarding mode passes raw trigger, unqualified; the code still gates it with the trigger enable.
// - Forwarded pulse has fixed polarity and duration.
// - Forwarding delay from trigger under 25 ns; the code takes three pclk cycles (150 ns) from pin to sync_out.
// - Copy mode copies CC1 after trigger accepted.
// - Copy mode decides accept or ignore within 1 us.
// - Sync copy follows CC1 within 25 ns.
// - Master still applies enable, detection, level.
// - Slave triggers from sync, ignores own settings.
// - Started slave waits armed for master signal.
// - Slaves start within about 0.8 us.
// - Debounce window 1 to 255 us, zero means 1.
// - CC1 is a driven camera control output.
module board_trigger_sync
   import trig_sync_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_trig_in,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe_n,
   output logic cc1_out,
   output logic acq_start
);

   // Software-visible state.
   cfg_t config_reg; // Source select and trigger qualification settings.
   logic [7:0] debounce_reg; // Debounce window in microseconds.
   logic [15:0] cc1_width_reg; // CC1 pulse length in clock cycles.
   logic [15:0] accept_cnt_reg; // Triggers that started an acquisition.
   logic [15:0] ignore_cnt_reg; // Triggers that were turned away.
   logic [31:0] prdata_reg; // Read data, captured in the setup phase.

   // Pin synchronisers; only the second stage is read by logic.
   logic ext_meta_reg;
   logic ext_sync_reg;
   logic sync_meta_reg;
   logic sync_line_reg;

   // Edge history.
   logic raw_prev_reg; // Previous undebounced trigger level.
   logic deb_prev_reg; // Previous debounced trigger level.
   logic sync_prev_reg; // Previous sync line level.

   // Acquisition and output state.
   acq_state_t state_reg;
   acq_state_t state_next;
   logic [15:0] cc1_cnt_reg; // Cycles of CC1 pulse already driven.
   logic [5:0] fwd_cnt_reg; // Remaining cycles of the forwarded pulse.
   logic [5:0] fwd_next;
   logic cc1_reg;
   logic sync_out_reg;
   logic sync_oe_n_reg;
   logic acq_start_reg;

   // Combinational terms.
   logic wr_access; // Write takes effect in this cycle.
   logic rd_setup; // Read request in its setup cycle.
   logic addr_mapped; // Address hits a register.
   logic cmd_write; // Command register written with lane 0 enabled.
   logic arm_cmd;
   logic disarm_cmd;
   logic sw_trig;
   logic clr_cnt;
   logic ext_level; // Isolated trigger after level inversion.
   logic deb_level; // Debounced trigger level.
   logic ext_event; // Qualified external trigger event.
   logic raw_event; // Leading edge for forwarding, gated only by the enable.
   logic sync_rise; // Assertion seen on the sync line.
   logic is_master;
   logic trig_event; // Trigger offered to the acquisition logic.
   logic fwd_event; // Trigger to forward in the forwarding mode.
   logic accept; // Trigger starts an acquisition.
   logic cc1_active; // CC1 asserted in the next cycle.
   logic [15:0] width_eff; // CC1 width with zero mapped to one.
   stat_t status;

   // The slave always answers in the access phase; no wait states.
   assign pready = 1'b1;
   assign wr_access = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pslverr = psel && penable && !addr_mapped;
   assign prdata = prdata_reg;
   assign cmd_write = wr_access && (paddr == OFS_COMMAND) && pstrb[0];
   assign arm_cmd = cmd_write && pwdata[CMD_ARM_BIT];
   assign disarm_cmd = cmd_write && pwdata[CMD_DISARM_BIT];
   assign sw_trig = cmd_write && pwdata[CMD_SW_TRIG_BIT];
   assign clr_cnt = cmd_write && pwdata[CMD_CLR_CNT_BIT];

   // Address decode for the error answer to reads and writes.
   always_comb begin
      if (paddr == OFS_CONFIG) begin
         addr_mapped = 1'b1;
      end else if (paddr == OFS_DEBOUNCE || paddr == OFS_CC1_WIDTH) begin
         addr_mapped = 1'b1;
      end else if (paddr == OFS_COMMAND || paddr == OFS_STATUS) begin
         addr_mapped = 1'b1;
      end else if (paddr == OFS_ACCEPT_CNT || paddr == OFS_IGNORE_CNT) begin
         addr_mapped = 1'b1;
      end else begin
         addr_mapped = 1'b0;
      end
   end

   // Configuration writes honour the byte strobes of the low lanes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg <= cfg_t'(CONFIG_RESET);
         debounce_reg <= DEBOUNCE_RESET;
         cc1_width_reg <= CC1_WIDTH_RESET;
      end else if (wr_access) begin
         if (paddr == OFS_CONFIG) begin
            config_reg <= pstrb[0] ? cfg_t'(pwdata[7:0]) : config_reg;
         end else if (paddr == OFS_DEBOUNCE) begin
            debounce_reg <= pstrb[0] ? pwdata[7:0] : debounce_reg;
         end else if (paddr == OFS_CC1_WIDTH) begin
            cc1_width_reg <= lane_merge(cc1_width_reg, pwdata[15:0], pstrb[1:0]);
         end
      end
   end

   // Read data is latched in the setup cycle so it is steady for the access.
   // Unmapped addresses and the write-only command register read as zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (rd_setup) begin
         if (paddr == OFS_CONFIG) begin
            prdata_reg <= {24'h00_0000, config_reg};
         end else if (paddr == OFS_DEBOUNCE) begin
            prdata_reg <= {24'h00_0000, debounce_reg};
         end else if (paddr == OFS_CC1_WIDTH) begin
            prdata_reg <= {16'h0000, cc1_width_reg};
         end else if (paddr == OFS_STATUS) begin
            prdata_reg <= {28'h000_0000, status};
         end else if (paddr == OFS_ACCEPT_CNT) begin
            prdata_reg <= {16'h0000, accept_cnt_reg};
         end else if (paddr == OFS_IGNORE_CNT) begin
            prdata_reg <= {16'h0000, ignore_cnt_reg};
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Both pins come from outside the clock domain: two flops each.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         sync_meta_reg <= 1'b0;
         sync_line_reg <= 1'b0;
      end else begin
         ext_meta_reg <= ext_trig_in;
         ext_sync_reg <= ext_meta_reg;
         sync_meta_reg <= sync_in;
         sync_line_reg <= sync_meta_reg;
      end
   end

   // Level setting inverts an active-low trigger before any detection.
   assign ext_level = ext_sync_reg ^ config_reg.level_low;

   trig_debounce u_debounce (
      .pclk(pclk),
      .presetn(presetn),
      .level_in(ext_level),
      .window_us(debounce_reg),
      .level_out(deb_level)
   );

   // Edge history for trigger, debounced trigger and sync line.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_prev_reg <= 1'b0;
         deb_prev_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
      end else begin
         raw_prev_reg <= ext_level;
         deb_prev_reg <= deb_level;
         sync_prev_reg <= sync_line_reg;
      end
   end

   // Enable and edge detection qualify the debounced trigger.
   always_comb begin
      if (config_reg.detect_trailing) begin
         ext_event = config_reg.trig_enable && !deb_level && deb_prev_reg;
      end else begin
         ext_event = config_reg.trig_enable && deb_level && !deb_prev_reg;
      end
   end

   // The forwarding path skips debounce and acquisition state on purpose.
   assign raw_event = config_reg.trig_enable && ext_level && !raw_prev_reg;
   assign sync_rise = sync_line_reg && !sync_prev_reg;
   assign is_master = (config_reg.src == SRC_MASTER_FWD) ||
                      (config_reg.src == SRC_MASTER_CC1);

   // Pick the trigger that drives this board's acquisition.
   always_comb begin
      case (config_reg.src)
         SRC_SW: trig_event = sw_trig;
         SRC_MASTER_FWD, SRC_MASTER_CC1: begin
            trig_event = config_reg.use_sw ? sw_trig : ext_event;
         end
         SRC_SLAVE: trig_event = sync_rise;
         default: trig_event = ext_event;
      endcase
   end

   assign fwd_event = config_reg.use_sw ? sw_trig : raw_event;

   // A trigger is used only while armed; the decision is made in the same
   // cycle the event is seen, far inside one microsecond.
   assign accept = (state_reg == ACQ_ARMED) && trig_event && !disarm_cmd;
   assign width_eff = at_least_one(cc1_width_reg);

   // Acquisition control: armed waits for a trigger, pulse drives CC1.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ACQ_IDLE: begin
            if (arm_cmd) begin
               state_next = ACQ_ARMED;
            end
         end
         ACQ_ARMED: begin
            if (disarm_cmd) begin
               state_next = ACQ_IDLE;
            end else if (accept) begin
               state_next = ACQ_PULSE;
            end
         end
         ACQ_PULSE: begin
            if (cc1_cnt_reg + 16'h0001 >= width_eff) begin
               state_next = ACQ_IDLE;
            end
         end
         default: state_next = ACQ_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ACQ_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Count the cycles of the CC1 pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc1_cnt_reg <= 16'h0000;
      end else if (state_reg == ACQ_PULSE) begin
         cc1_cnt_reg <= cc1_cnt_reg + 16'h0001;
      end else begin
         cc1_cnt_reg <= 16'h0000;
      end
   end

   assign cc1_active = (state_next == ACQ_PULSE);

   // Forwarded pulse: fixed length, retriggers during it are dropped.
   always_comb begin
      if (fwd_cnt_reg != 6'h00) begin
         fwd_next = fwd_cnt_reg - 6'h01;
      end else if (fwd_event && config_reg.src == SRC_MASTER_FWD) begin
         fwd_next = SYNC_PULSE_LOAD;
      end else begin
         fwd_next = 6'h00;
      end
   end

   // Forward pulse counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_cnt_reg <= 6'h00;
      end else begin
         fwd_cnt_reg <= fwd_next;
      end
   end

   // CC1 and the sync copy load from the same term on the same edge, so
   // their skew is zero cycles; only board routing separates them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc1_reg <= 1'b0;
         sync_out_reg <= 1'b0;
         sync_oe_n_reg <= 1'b1;
         acq_start_reg <= 1'b0;
      end else begin
         cc1_reg <= cc1_active ^ config_reg.cc1_low;
         if (config_reg.src == SRC_MASTER_CC1) begin
            sync_out_reg <= cc1_active ^ config_reg.cc1_low;
         end else if (config_reg.src == SRC_MASTER_FWD) begin
            sync_out_reg <= (fwd_next != 6'h00);
         end else begin
            sync_out_reg <= 1'b0;
         end
         sync_oe_n_reg <= !is_master;
         acq_start_reg <= accept;
      end
   end

   // Event counters; a clear loses to a simultaneous count only by one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accept_cnt_reg <= 16'h0000;
         ignore_cnt_reg <= 16'h0000;
      end else begin
         if (accept) begin
            accept_cnt_reg <= clr_cnt ? 16'h0001 : accept_cnt_reg + 16'h0001;
         end else if (clr_cnt) begin
            accept_cnt_reg <= 16'h0000;
         end
         if (trig_event && !accept) begin
            ignore_cnt_reg <= clr_cnt ? 16'h0001 : ignore_cnt_reg + 16'h0001;
         end else if (clr_cnt) begin
            ignore_cnt_reg <= 16'h0000;
         end
      end
   end

   // Status view of the block's own state.
   always_comb begin
      status.armed = (state_reg == ACQ_ARMED);
      status.pulse_busy = (state_reg == ACQ_PULSE);
      status.sync_driving = !sync_oe_n_reg;
      status.sync_level = sync_line_reg;
   end

   assign sync_out = sync_out_reg;
   assign sync_oe_n = sync_oe_n_reg;
   assign cc1_out = cc1_reg;
   assign acq_start = acq_start_reg;

endmodule

// *** sim/trig_sync_sva.sv ***
// Port-level assertions for the multi-board trigger synchroniser.
`timescale 1ns/100ps
module trig_sync_sva
   import trig_sync_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic ext_trig_in,
   input wire logic sync_in,
   input wire logic sync_out,
   input wire logic sync_oe_n,
   input wire logic cc1_out,
   input wire logic acq_start
);
   cfg_t cfg_reg; // Shadow of the configuration word.
   logic [15:0] width_reg; // Shadow of the CC1 width.
   logic sync_prev_reg; // Sync line level at the last edge.
   logic [7:0] since_reg; // Edges since the sync line last rose.
   logic [7:0] high_reg; // Length of the running sync pulse.
   logic [15:0] cc_reg; // Length of the running CC1 pulse.
   logic wr_acc; // A write completes at this edge.
   assign wr_acc = psel && penable && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadows follow completed writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= cfg_t'(CONFIG_RESET);
         width_reg <= CC1_WIDTH_RESET;
      end else if (wr_acc && paddr == OFS_CONFIG && pstrb[0]) begin
         cfg_reg <= cfg_t'(pwdata[7:0]);
      end else if (wr_acc && paddr == OFS_CC1_WIDTH) begin
         width_reg[7:0] <= pstrb[0] ? pwdata[7:0] : width_reg[7:0];
         width_reg[15:8] <= pstrb[1] ? pwdata[15:8] : width_reg[15:8];
      end
   end
   // Pulse lengths and age of the last sync rise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_prev_reg <= 1'b0;
         since_reg <= 8'hff;
         high_reg <= 8'h00;
         cc_reg <= 16'h0000;
      end else begin
         sync_prev_reg <= sync_in;
         since_reg <= (sync_in && !sync_prev_reg) ? 8'h00 : since_reg + 8'(since_reg != 8'hff);
         high_reg <= sync_out ? high_reg + 8'h01 : 8'h00;
         cc_reg <= (cc1_out ^ cfg_reg.cc1_low) ? cc_reg + 16'h0001 : 16'h0000;
      end
   end
   a_slave_no_drive: assert property (
      !(cfg_reg.src inside {SRC_MASTER_FWD, SRC_MASTER_CC1}) [*2] |-> sync_oe_n)
      else $error("slave drives sync");
   a_master_drives: assert property (
      (cfg_reg.src inside {SRC_MASTER_FWD, SRC_MASTER_CC1}) [*2] |-> !sync_oe_n)
      else $error("master not driving sync");
   a_copy_follows: assert property (
      (cfg_reg.src == SRC_MASTER_CC1 && !cfg_reg.cc1_low) [*2] |-> sync_out == cc1_out)
      else $error("sync copy differs from CC1");
   a_copy_start: assert property (
      acq_start && cfg_reg.src == SRC_MASTER_CC1 && !cfg_reg.cc1_low |-> cc1_out && sync_out)
      else $error("no CC1 or sync pulse");
   a_fwd_length: assert property (
      $fell(sync_out) && cfg_reg.src == SRC_MASTER_FWD |-> high_reg == 8'(SYNC_PULSE_CYCLES))
      else $error("forward pulse length wrong");
   a_fwd_delay: assert property (
      $rose(sync_out) && cfg_reg.src == SRC_MASTER_FWD
      |-> ($past(ext_trig_in, 3) != cfg_reg.level_low) && ($past(ext_trig_in, 5) == cfg_reg.level_low))
      else $error("forward delay wrong");
   a_slave_start: assert property (
      acq_start && cfg_reg.src == SRC_SLAVE |-> since_reg <= 8'd16)
      else $error("slave start too late after sync");
   a_cc1_width: assert property (
      $fell(cc1_out) && !cfg_reg.cc1_low |-> cc_reg == ((width_reg == 16'h0000) ? 16'h0001 : width_reg))
      else $error("CC1 pulse width wrong");
   c_slave: cover property (acq_start && cfg_reg.src == SRC_SLAVE);
   c_fwd: cover property ($fell(sync_out) && cfg_reg.src == SRC_MASTER_FWD);
   c_copy: cover property (acq_start && cfg_reg.src == SRC_MASTER_CC1);
endmodule
bind board_trigger_sync trig_sync_sva trig_sync_sva_i (.*);

// *** sim/sync_slave_model.sv ***
// Model of another board sharing the sync line.
`timescale 1ns/100ps
module sync_slave_model (
   input wire logic pclk,
   input wire logic sync_out,
   input wire logic sync_oe_n,
   input wire logic master_en,
   input wire logic master_val,
   output logic line,
   output int starts,
   output int clashes
);
   logic prev; // Line level at the last edge.
   // Driver sets the wire; undriven, the pull-down holds it low.
   assign line = !sync_oe_n ? sync_out : (master_en ? master_val : 1'b0);
   initial begin
      starts = 0;
      clashes = 0;
      prev = 1'b0;
   end
   // Counts starts per rise and double drives.
   always @(posedge pclk) begin
      if (line && !prev) starts <= starts + 1;
      if (!sync_oe_n && master_en) clashes <= clashes + 1;
      prev <= line;
   end
endmodule

// *** sim/test_multi_board_trigger_sync.sv ***
// Self-checking bench for the multi-board trigger synchroniser.
`timescale 1ns/100ps
module test_multi_board_trigger_sync;
   import trig_sync_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf; // All lanes always written.
   logic ext_trig_in = 1'b0;
   logic master_en = 1'b0; // The other board drives the line.
   logic master_val = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, sync_line, sync_out, sync_oe_n, cc1_out, acq_start;
   int starts, clashes;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   board_trigger_sync board_trigger_sync_i (.sync_in(sync_line), .*);
   sync_slave_model sync_slave_model_i (.line(sync_line), .*);
   // A 20 MHz clock.
   always #25 pclk = ~pclk;
   // Compares and counts; an unknown bit matches only an unknown bit.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // Counts, verdict, stop.
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer, held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   // Edges until a start is seen; lim + 1 means none came.
   task automatic wait_acq(input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(posedge pclk);
         if (acq_start === 1'b1) return;
      end
   endtask
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      rd(OFS_CONFIG, q);
      chk(q, 32'(CONFIG_RESET));
      rd(OFS_DEBOUNCE, q);
      chk(q, 32'h1);
      rd(OFS_CC1_WIDTH, q);
      chk(q, 32'h14);
      wr(OFS_DEBOUNCE, 32'hff);
      rd(OFS_DEBOUNCE, q);
      chk(q, 32'hff);
      apb(1'b0, 8'h1c, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      $display("test regs done");
   endtask
   // Forwarding: short and long triggers, same pulse.
   task automatic t_fwd();
      int first, high, s0;
      wr(OFS_CONFIG, 32'h0a);
      for (int w = 3; w <= 43; w += 40) begin
         s0 = starts;
         first = 0;
         high = 0;
         ext_trig_in <= 1'b1;
         for (int k = 1; k <= 60; k++) begin
            @(posedge pclk);
            if (k == w) ext_trig_in <= 1'b0;
            if (sync_out === 1'b1 && first == 0) first = k;
            if (sync_out === 1'b1) high++;
         end
         chk(first, 4);
         chk(high, SYNC_PULSE_CYCLES);
         chk(starts - s0, 1);
      end
      $display("test forward done");
   endtask
   // Copy mode at both trigger levels: glitch, accept, ignore.
   task automatic t_copy();
      logic [31:0] q;
      int n, w;
      wr(OFS_DEBOUNCE, 32'h0);
      wr(OFS_CC1_WIDTH, 32'h5);
      for (int lv = 0; lv < 2; lv++) begin
         ext_trig_in <= lv[0];
         wr(OFS_CONFIG, 32'h0b | (lv << 4));
         repeat (60) @(posedge pclk);
         wr(OFS_COMMAND, 32'h9);
         ext_trig_in <= ~lv[0];
         repeat (10) @(posedge pclk);
         ext_trig_in <= lv[0];
         wait_acq(60, n);
         chk(n, 61);
         ext_trig_in <= ~lv[0];
         wait_acq(45, n);
         chk(n <= 45, 1);
         chk({cc1_out, sync_out}, 2'b11);
         w = 1;
         while (cc1_out === 1'b1 && w < 50) begin
            @(posedge pclk);
            chk(sync_out, cc1_out);
            if (cc1_out === 1'b1) w++;
         end
         chk(w, 5);
         ext_trig_in <= lv[0];
         repeat (40) @(posedge pclk);
         ext_trig_in <= ~lv[0];
         wait_acq(60, n);
         chk(n, 61);
         ext_trig_in <= lv[0];
         rd(OFS_ACCEPT_CNT, q);
         chk(q, 32'h1);
         rd(OFS_IGNORE_CNT, q);
         chk(q, 32'h1);
      end
      wr(OFS_CONFIG, 32'h03);
      ext_trig_in <= 1'b0;
      repeat (60) @(posedge pclk);
      wr(OFS_COMMAND, 32'h1);
      ext_trig_in <= 1'b1;
      wait_acq(60, n);
      chk(n, 61);
      ext_trig_in <= 1'b0;
      wr(OFS_COMMAND, 32'h2);
      $display("test copy done");
   endtask
   // Software trigger, as master copy and as plain source.
   task automatic t_sw();
      int n;
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CONFIG, i ? 32'h09 : 32'h4b);
         wr(OFS_COMMAND, 32'h1);
         wr(OFS_COMMAND, 32'h4);
         wait_acq(45, n);
         chk(n <= 45, 1);
         chk(sync_out, i == 0);
         chk(sync_oe_n, i);
         repeat (30) @(posedge pclk);
      end
      $display("test software done");
   endtask
   // Slave: own trigger ignored, waits armed, starts from the line.
   task automatic t_slave();
      int n;
      wr(OFS_CONFIG, 32'h34);
      repeat (5) @(posedge pclk);
      chk(sync_oe_n, 1'b1);
      for (int arm = 0; arm < 2; arm++) begin
         if (arm == 1) wr(OFS_COMMAND, 32'h1);
         ext_trig_in <= 1'b1;
         wait_acq(40, n);
         chk(n, 41);
         ext_trig_in <= 1'b0;
         master_en <= 1'b1;
         master_val <= 1'b1;
         wait_acq(16, n);
         chk(n <= 16, arm);
         repeat (5) @(posedge pclk);
         master_val <= 1'b0;
         repeat (5) @(posedge pclk);
         master_en <= 1'b0;
      end
      chk(clashes, 0);
      $display("test slave done");
   endtask
   // Main sequence after ten cycles of reset.
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_fwd();
      t_copy();
      t_sw();
      t_slave();
      wrap_up();
   end
   // Cuts a hang short.
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         wrap_up();
      end
   end
endmodule
